/* hw/dsw_consts.vh */
// Constants for the drive status word builder: register offsets, field
// positions, reset values and fixed widths.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH

// Register byte offsets.
`define DSW_OFF_STATE    8'h00
`define DSW_OFF_CTRL     8'h04
`define DSW_OFF_LOW_SPD  8'h08
`define DSW_OFF_HIGH_SPD 8'h0c
`define DSW_OFF_TOL      8'h10
`define DSW_OFF_IRQ_STS  8'h14
`define DSW_OFF_IRQ_MASK 8'h18

// Reset values.
`define DSW_RST_CTRL     1'b0
`define DSW_RST_LOW_SPD  16'h0000
`define DSW_RST_HIGH_SPD 16'hffff
`define DSW_RST_TOL      16'h0000
`define DSW_RST_MASK     5'h00

// Control register field.
`define DSW_CTRL_IO_PROFILE 0

// Status word field positions.
`define DSW_B_RTSO   0
`define DSW_B_SWON   1
`define DSW_B_OPEN   2
`define DSW_B_ERR    3
`define DSW_B_SUPPLY 4
`define DSW_B_QSTOP  5
`define DSW_B_SOD    6
`define DSW_B_WARN   7
`define DSW_B_REMOTE 9
`define DSW_B_REACH  10
`define DSW_B_LIMIT  11
`define DSW_B_STOPK  14
`define DSW_B_DIR    15

// Interrupt event bits.
`define DSW_EV_ERR   0
`define DSW_EV_WARN  1
`define DSW_EV_REACH 2
`define DSW_EV_LIMIT 3
`define DSW_EV_STOPK 4
`define DSW_EV_N     5

// Bus answers.
`define DSW_RESP_OKAY   2'b00
`define DSW_RESP_SLVERR 2'b10

`endif

/* hw/dsw_speed_cmp.v */
// Speed reference comparator: reference reached and outside limits.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dsw_speed_cmp (
	// Mode and external results
	input  wire        speed_mode,
	input  wire        ext_reached,
	input  wire        ext_outside,
	// Speed values, unsigned magnitudes
	input  wire [15:0] speed_ref,
	input  wire [15:0] speed_act,
	input  wire [15:0] low_speed_limit,
	input  wire [15:0] high_speed_limit,
	input  wire [15:0] reach_tol,
	// Results
	output wire        reached,
	output wire        outside
);
	wire [15:0] diff;

	assign diff = (speed_act > speed_ref) ? (speed_act - speed_ref)
		: (speed_ref - speed_act);
	// In speed mode the speed reference is the compared target.
	assign reached = speed_mode ? (diff <= reach_tol)
		: ext_reached;
	assign outside = speed_mode ? ((speed_ref < low_speed_limit) |
		(speed_ref > high_speed_limit)) : ext_outside;
endmodule // dsw_speed_cmp
`default_nettype wire

/* hw/dsw_event_irq.v */
// Sticky event flags with write-one-to-clear, mask and interrupt level.
// Assumes events and clears are on the same clock as the flags.
`timescale 1ns/1ns
`default_nettype none
`include "dsw_consts.vh"
module dsw_event_irq (
	// Clock and control
	input  wire                   clk_sys,
	input  wire                   rstn,
	input  wire                   ce,
	// Event levels, clear pulses, mask
	input  wire [`DSW_EV_N-1:0]   evt,
	input  wire [`DSW_EV_N-1:0]   clr,
	input  wire [`DSW_EV_N-1:0]   mask,
	// Flags and interrupt
	output wire [`DSW_EV_N-1:0]   sts,
	output reg                    irq_ff
);
	reg  [`DSW_EV_N-1:0] prev_ff;
	reg  [`DSW_EV_N-1:0] sts_ff;
	genvar i;

	generate
		for (i = 0; i < `DSW_EV_N; i = i + 1) begin : g_flag
			// A rising event in the clear cycle keeps the flag set.
			always @(posedge clk_sys) begin
				if (!rstn) begin
					prev_ff[i] <= 1'b0;
					sts_ff[i]  <= 1'b0;
				end else if (ce) begin
					prev_ff[i] <= evt[i];
					if (evt[i] & ~prev_ff[i])
						sts_ff[i] <= 1'b1;
					else if (clr[i])
						sts_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge clk_sys) begin
		if (!rstn)
			irq_ff <= 1'b0;
		else if (ce)
			irq_ff <= |(sts_ff & mask);
	end

	assign sts = sts_ff;
endmodule // dsw_event_irq
`default_nettype wire

/* hw/dsw_status_top.v */
// Drive status word builder with AXI4-Lite register access.
// Registers: status word, control, speed limits, reach tolerance,
// event flags and event mask.
// Assumes condition inputs come from drive logic on clk_sys; the
// AXI4-Lite master runs on clk_sys as well.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "dsw_consts.vh"
module dsw_status_top (
	// Clock, reset, enable
	input  wire        clk_sys,
	input  wire        rstn,
	input  wire        ce,
	// State machine flags
	input  wire        sm_ready_on,
	input  wire        sm_switched_on,
	input  wire        sm_op_enabled,
	input  wire        sm_quick_stop,
	input  wire        sm_switch_on_disabled,
	// I/O profile flags
	input  wire        io_ready,
	input  wire        io_running,
	// Drive conditions
	input  wire        err_active,
	input  wire        warn_active,
	input  wire        supply_present,
	input  wire        power_section_only,
	input  wire        cmd_from_network,
	input  wire        stop_key_stop,
	input  wire        dir_reverse,
	// Reference comparison
	input  wire        speed_mode,
	input  wire        ext_reached,
	input  wire        ext_outside,
	input  wire [15:0] speed_ref,
	input  wire [15:0] speed_act,
	// AXI4-Lite write address
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	// AXI4-Lite write data
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	// AXI4-Lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// Status word and interrupt
	output reg  [15:0] drive_state_word_ff,
	output wire        irq
);
	// Software registers. The limits reset wide open, so in speed mode the
	// limit bit stays low until software programs them.
	reg         io_profile_ff;
	reg  [15:0] low_speed_limit_ff;
	reg  [15:0] high_speed_limit_ff;
	reg  [15:0] reach_tol_ff;
	reg  [`DSW_EV_N-1:0] irq_mask_ff;

	// Write channel holding state.
	// Address and data wait here until the other half has arrived.
	reg         aw_hold_ff;
	reg  [7:0]  aw_addr_ff;
	reg         w_hold_ff;
	reg  [31:0] w_data_ff;
	reg  [3:0]  w_strb_ff;

	// Derived status and bus terms.
	reg  [15:0] nxt_word;
	reg  [31:0] nxt_rdata;
	reg  [1:0]  nxt_rresp;
	reg         wr_hit;
	wire        do_wr;
	wire [`DSW_EV_N-1:0] irq_clr;
	wire [`DSW_EV_N-1:0] irq_sts;
	wire [`DSW_EV_N-1:0] events;
	wire        reached;
	wire        outside;
	wire        supply_bit;
	wire [15:0] wr_half;

	// Reference comparison.
	// Outside speed mode the comparator passes the drive's own results.
	dsw_speed_cmp u_cmp (
		.speed_mode       (speed_mode),
		.ext_reached      (ext_reached),
		.ext_outside      (ext_outside),
		.speed_ref        (speed_ref),
		.speed_act        (speed_act),
		.low_speed_limit  (low_speed_limit_ff),
		.high_speed_limit (high_speed_limit_ff),
		.reach_tol        (reach_tol_ff),
		.reached          (reached),
		.outside          (outside)
	);

	// Event flags and interrupt.
	// Each flag records a rising edge of its condition, so a level that
	// stays high raises the interrupt once until software clears it.
	assign events[`DSW_EV_ERR]   = err_active;
	assign events[`DSW_EV_WARN]  = warn_active;
	assign events[`DSW_EV_REACH] = reached;
	assign events[`DSW_EV_LIMIT] = outside;
	assign events[`DSW_EV_STOPK] = stop_key_stop;

	dsw_event_irq u_irq (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.evt     (events),
		.clr     (irq_clr),
		.mask    (irq_mask_ff),
		.sts     (irq_sts),
		.irq_ff  (irq)
	);

	// With power only through the power section the supply is present.
	assign supply_bit = supply_present | power_section_only;

	// In the I/O layout bits 0 and 6 may read either way; they report
	// zero, and bit 5 is fixed at one.
	// Status word assembly for both layouts.
	always @* begin
		nxt_word = 16'h0000;
		nxt_word[`DSW_B_ERR]    = err_active;
		nxt_word[`DSW_B_SUPPLY] = supply_bit;
		nxt_word[`DSW_B_WARN]   = warn_active;
		nxt_word[`DSW_B_REMOTE] = cmd_from_network;
		nxt_word[`DSW_B_REACH]  = reached;
		nxt_word[`DSW_B_LIMIT]  = outside;
		nxt_word[`DSW_B_STOPK]  = stop_key_stop;
		nxt_word[`DSW_B_DIR]    = dir_reverse;
		if (io_profile_ff) begin
			nxt_word[`DSW_B_SWON]  = io_ready;
			nxt_word[`DSW_B_OPEN]  = io_running;
			nxt_word[`DSW_B_QSTOP] = 1'b1;
		end else begin
			// The five state bits together give the drive state.
			nxt_word[`DSW_B_RTSO]  = sm_ready_on;
			nxt_word[`DSW_B_SWON]  = sm_switched_on;
			nxt_word[`DSW_B_OPEN]  = sm_op_enabled;
			nxt_word[`DSW_B_QSTOP] = sm_quick_stop;
			nxt_word[`DSW_B_SOD]   = sm_switch_on_disabled;
		end
	end

	// The word is registered so that a reader sees one value per cycle,
	// whatever the condition inputs do between edges.
	always @(posedge clk_sys) begin
		if (!rstn)
			drive_state_word_ff <= 16'h0000;
		else if (ce)
			drive_state_word_ff <= nxt_word;
	end

	// Write address and data are taken independently, in either order.
	// The response is held back until both halves of the write are in.
	assign do_wr = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;

	// Byte strobes apply to the low half word of 16-bit registers.
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge16 = {strb[1] ? data[15:8] : old[15:8],
				strb[0] ? data[7:0] : old[7:0]};
		end
	endfunction

	assign wr_half = w_data_ff[15:0];
	// Write-one-to-clear of the event flags; a clear that meets a new
	// event in the same cycle loses, so no event is missed.
	assign irq_clr = (do_wr && aw_addr_ff == `DSW_OFF_IRQ_STS &&
		w_strb_ff[0]) ? w_data_ff[`DSW_EV_N-1:0] : {`DSW_EV_N{1'b0}};

	// Every mapped offset, the read-only word included, answers OKAY.
	always @* begin
		case (aw_addr_ff)
		`DSW_OFF_STATE,
		`DSW_OFF_CTRL,
		`DSW_OFF_LOW_SPD,
		`DSW_OFF_HIGH_SPD,
		`DSW_OFF_TOL,
		`DSW_OFF_IRQ_STS,
		`DSW_OFF_IRQ_MASK: wr_hit = 1'b1;
		default:           wr_hit = 1'b0;
		endcase
	end

	// Ready policy: awready and wready stay high while idle, drop on
	// their own handshake, and return only after the response has been
	// taken, so at most one write is in flight. Everything here holds
	// while ce is low.
	always @(posedge clk_sys) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DSW_RESP_OKAY;
			aw_hold_ff    <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_hold_ff     <= 1'b0;
			w_data_ff     <= 32'h00000000;
			w_strb_ff     <= 4'h0;
		end else if (ce) begin
			if (!aw_hold_ff && !s_axi_bvalid)
				s_axi_awready <= ~(s_axi_awvalid & s_axi_awready);
			if (!w_hold_ff && !s_axi_bvalid)
				s_axi_wready <= ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff    <= 1'b1;
				aw_addr_ff    <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff    <= 1'b1;
				w_data_ff    <= s_axi_wdata;
				w_strb_ff    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_hold_ff   <= 1'b0;
				w_hold_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `DSW_RESP_OKAY
					: `DSW_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Register writes; the status word itself takes no write.
	always @(posedge clk_sys) begin
		if (!rstn) begin
			io_profile_ff       <= `DSW_RST_CTRL;
			low_speed_limit_ff  <= `DSW_RST_LOW_SPD;
			high_speed_limit_ff <= `DSW_RST_HIGH_SPD;
			reach_tol_ff        <= `DSW_RST_TOL;
			irq_mask_ff         <= `DSW_RST_MASK;
		end else if (ce && do_wr) begin
			case (aw_addr_ff)
			`DSW_OFF_STATE: begin
				io_profile_ff <= io_profile_ff;
			end
			`DSW_OFF_CTRL: begin
				if (w_strb_ff[0])
					io_profile_ff <= wr_half[`DSW_CTRL_IO_PROFILE];
			end
			`DSW_OFF_LOW_SPD: begin
				low_speed_limit_ff <= merge16(low_speed_limit_ff,
					w_data_ff, w_strb_ff);
			end
			`DSW_OFF_HIGH_SPD: begin
				high_speed_limit_ff <= merge16(high_speed_limit_ff,
					w_data_ff, w_strb_ff);
			end
			`DSW_OFF_TOL: begin
				reach_tol_ff <= merge16(reach_tol_ff, w_data_ff,
					w_strb_ff);
			end
			`DSW_OFF_IRQ_MASK: begin
				if (w_strb_ff[0])
					irq_mask_ff <= wr_half[`DSW_EV_N-1:0];
			end
			default: begin
				io_profile_ff <= io_profile_ff;
			end
			endcase
		end
	end

	// Read data multiplexer.
	// Unmapped reads answer with zero data and an error response.
	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_rresp = `DSW_RESP_OKAY;
		case ({s_axi_araddr[7:2], 2'b00})
		`DSW_OFF_STATE:
			nxt_rdata[15:0] = drive_state_word_ff;
		`DSW_OFF_CTRL:
			nxt_rdata[`DSW_CTRL_IO_PROFILE] = io_profile_ff;
		`DSW_OFF_LOW_SPD:
			nxt_rdata[15:0] = low_speed_limit_ff;
		`DSW_OFF_HIGH_SPD:
			nxt_rdata[15:0] = high_speed_limit_ff;
		`DSW_OFF_TOL:
			nxt_rdata[15:0] = reach_tol_ff;
		`DSW_OFF_IRQ_STS:
			nxt_rdata[`DSW_EV_N-1:0] = irq_sts;
		`DSW_OFF_IRQ_MASK:
			nxt_rdata[`DSW_EV_N-1:0] = irq_mask_ff;
		default:
			nxt_rresp = `DSW_RESP_SLVERR;
		endcase
	end

	// A read is answered on the same edge that takes its address; arready
	// stays low until the data has been accepted.
	always @(posedge clk_sys) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `DSW_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= nxt_rdata;
				s_axi_rresp   <= nxt_rresp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // dsw_status_top
`default_nettype wire

/* test/dsw_axi_master.sv */
// AXI4-Lite master model standing for the network master.
// Assumes a slave on clk_sys; every task waits for the next rising edge.
`timescale 1ns/1ns
`default_nettype none
module dsw_axi_master (
	// Clock
	input  wire logic        clk_sys,
	// Write side
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [7:0]  s_axi_awaddr,
	output var  logic [2:0]  s_axi_awprot,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	// Read side
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	output var  logic [7:0]  s_axi_araddr,
	output var  logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	initial begin
		{s_axi_awvalid, s_axi_awaddr, s_axi_awprot, s_axi_wvalid} = '0;
		{s_axi_wdata, s_axi_wstrb, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_araddr, s_axi_arprot, s_axi_rready} = '0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
	endtask
endmodule // dsw_axi_master
`default_nettype wire

/* test/dsw_status_chk.sv */
// Checker for the status word at the ports of dsw_status_top.
// Assumes one clock domain and a bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module dsw_status_chk (
	// Clock, reset, enable
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        ce,
	// Drive conditions
	input wire logic        sm_ready_on,
	input wire logic        sm_switched_on,
	input wire logic        sm_op_enabled,
	input wire logic        sm_quick_stop,
	input wire logic        sm_switch_on_disabled,
	input wire logic        io_ready,
	input wire logic        io_running,
	input wire logic        err_active,
	input wire logic        warn_active,
	input wire logic        supply_present,
	input wire logic        power_section_only,
	input wire logic        cmd_from_network,
	input wire logic        stop_key_stop,
	input wire logic        dir_reverse,
	input wire logic        speed_mode,
	input wire logic        ext_reached,
	input wire logic        ext_outside,
	input wire logic [15:0] speed_ref,
	input wire logic [15:0] speed_act,
	// Status word
	input wire logic [15:0] drive_state_word_ff
);
	logic       prv_ff;
	wire [15:0] w = drive_state_word_ff;
	wire        en = ce & prv_ff;

	always_ff @(posedge clk_sys) begin
		prv_ff <= rstn;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_cia;
		{w[6:5], w[2:0]} == {$past(sm_switch_on_disabled),
			$past(sm_quick_stop), $past(sm_op_enabled),
			$past(sm_switched_on), $past(sm_ready_on)};
	endsequence
	sequence s_io;
		{w[6:5], w[2:0]} == {2'b01, $past(io_running), $past(io_ready), 1'b0};
	endsequence

	property p_lay;
		en |=> s_cia or s_io;
	endproperty
	a_lay: assert property (p_lay) else $error("state bits wrong");
	property p_err;
		en |=> w[3] == $past(err_active);
	endproperty
	a_err: assert property (p_err) else $error("error bit wrong");
	property p_sup;
		en |=> w[4] == ($past(supply_present) | $past(power_section_only));
	endproperty
	a_sup: assert property (p_sup) else $error("supply bit wrong");
	property p_net;
		en |=> w[9] == $past(cmd_from_network);
	endproperty
	a_net: assert property (p_net) else $error("source bit wrong");
	property p_ext;
		en && !speed_mode |=> w[11:10] == {$past(ext_outside),
			$past(ext_reached)};
	endproperty
	a_ext: assert property (p_ext) else $error("reach bits wrong");
	property p_eq;
		en && speed_mode && speed_ref == speed_act |=> w[10];
	endproperty
	a_eq: assert property (p_eq) else $error("speed reach wrong");
	property p_stop;
		en |=> w[14] == $past(stop_key_stop);
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit wrong");
	property p_dir;
		en |=> w[15] == $past(dir_reverse);
	endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	property p_rsv;
		en |=> w[13:12] == 2'b00 && !w[8] && w[7] == $past(warn_active);
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved wrong");
	property p_frz;
		!ce && prv_ff |=> $stable(w);
	endproperty
	a_frz: assert property (p_frz) else $error("word moved");
endmodule // dsw_status_chk

bind dsw_status_top dsw_status_chk u_chk (.clk_sys, .rstn, .ce,
	.sm_ready_on, .sm_switched_on, .sm_op_enabled, .sm_quick_stop,
	.sm_switch_on_disabled, .io_ready, .io_running, .err_active,
	.warn_active, .supply_present, .power_section_only, .cmd_from_network,
	.stop_key_stop, .dir_reverse, .speed_mode, .ext_reached, .ext_outside,
	.speed_ref, .speed_act, .drive_state_word_ff);
`default_nettype wire

/* test/drive_status_word_builder_bench.sv */
// Self-checking bench for the drive status word builder.
// Assumes the design, its checker and the bus master model.
`timescale 1ns/1ns
`default_nettype none
module drive_status_word_builder_bench;
	logic        clk_sys, rstn, ce, io;
	logic        sm_ready_on, sm_switched_on, sm_op_enabled, sm_quick_stop;
	logic        sm_switch_on_disabled, io_ready, io_running, err_active;
	logic        warn_active, supply_present, power_section_only;
	logic        cmd_from_network, stop_key_stop, dir_reverse, speed_mode;
	logic        ext_reached, ext_outside;
	logic [15:0] speed_ref, speed_act, lo, hi, tol, w0;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          n_errors, samples_checked, cyc;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire         s_axi_rvalid, s_axi_rready, irq;
	wire [7:0]   s_axi_awaddr, s_axi_araddr;
	wire [2:0]   s_axi_awprot, s_axi_arprot;
	wire [31:0]  s_axi_wdata, s_axi_rdata;
	wire [3:0]   s_axi_wstrb;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [15:0]  drive_state_word_ff;

	dsw_status_top uut (.clk_sys, .rstn, .ce, .sm_ready_on, .sm_switched_on,
		.sm_op_enabled, .sm_quick_stop, .sm_switch_on_disabled, .io_ready,
		.io_running, .err_active, .warn_active, .supply_present,
		.power_section_only, .cmd_from_network, .stop_key_stop,
		.dir_reverse, .speed_mode, .ext_reached, .ext_outside, .speed_ref,
		.speed_act, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.drive_state_word_ff, .irq);
	dsw_axi_master m (.clk_sys, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_rvalid, .s_axi_rready);

	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [33:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic bwr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bq.push_back(r);
		m.wr(a, d);
	endtask

	task automatic brd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		m.rd(a);
	endtask

	task automatic setc(input logic [16:0] v);
		{sm_ready_on, sm_switched_on, sm_op_enabled, sm_quick_stop,
			sm_switch_on_disabled, io_ready, io_running, err_active,
			warn_active, supply_present, power_section_only,
			cmd_from_network, stop_key_stop, dir_reverse, speed_mode,
			ext_reached, ext_outside} <= v;
	endtask

	task automatic rnd();
		logic [15:0] r;
		r = 16'($urandom_range(60000, 100));
		setc(17'($urandom));
		speed_ref <= r;
		speed_act <= r + 16'($urandom_range(10, 0)) - 16'h0005;
		repeat (2) @(posedge clk_sys);
	endtask

	function automatic logic [15:0] ew();
		logic [15:0] d;
		logic        rch;
		logic        lim;
		d = speed_act > speed_ref ? speed_act - speed_ref
			: speed_ref - speed_act;
		rch = speed_mode ? d <= tol : ext_reached;
		lim = speed_mode ? speed_ref < lo || speed_ref > hi : ext_outside;
		ew = {dir_reverse, stop_key_stop, 2'b00, lim, rch, cmd_from_network,
			1'b0, warn_active,
			io ? 2'b01 : {sm_switch_on_disabled, sm_quick_stop},
			supply_present | power_section_only, err_active,
			io ? {io_running, io_ready, 1'b0}
			: {sm_op_enabled, sm_switched_on, sm_ready_on}};
	endfunction

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Completed transfers are compared against the oldest expectation.
	always @(posedge clk_sys) begin
		if (s_axi_rvalid && s_axi_rready)
			chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end

	initial begin
		logic [7:0]  ra[5];
		logic [15:0] rv[5];
		ra = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
		rv = '{16'h0, 16'h0, 16'hffff, 16'h0, 16'h0};
		void'($urandom(59160));
		rstn = 1'b0;
		ce = 1'b1;
		io = 1'b0;
		setc(17'h0);
		speed_ref = 16'h0000;
		speed_act = 16'h0000;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++)
			brd(ra[i], {18'h0, rv[i]});
		lo = 16'd1000;
		hi = 16'd50000;
		tol = 16'h0004;
		bwr(8'h08, {16'h0, lo}, 2'b00);
		bwr(8'h0c, {16'h0, hi}, 2'b00);
		bwr(8'h10, {16'h0, tol}, 2'b00);
		for (int k = 0; k < 2; k++) begin
			io = k[0];
			bwr(8'h04, {31'h0, io}, 2'b00);
			repeat (40) begin
				rnd();
				brd(8'h00, {18'h0, ew()});
			end
		end
		bwr(8'h00, 32'hffffffff, 2'b00);
		brd(8'h00, {18'h0, ew()});
		bwr(8'h1c, 32'h1, 2'b10);
		brd(8'h1c, {2'b10, 32'h0});
		setc(17'h0);
		repeat (2) @(posedge clk_sys);
		bwr(8'h14, 32'h1f, 2'b00);
		bwr(8'h18, 32'h1, 2'b00);
		chk("irq", 34'h0, {33'h0, irq});
		err_active <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("irq", 34'h1, {33'h0, irq});
		brd(8'h14, 34'h1);
		// The interrupt moves on the edge that ends the write; look later.
		bwr(8'h18, 32'h0, 2'b00);
		@(posedge clk_sys);
		chk("irq", 34'h0, {33'h0, irq});
		bwr(8'h18, 32'h1, 2'b00);
		@(posedge clk_sys);
		chk("irq", 34'h1, {33'h0, irq});
		bwr(8'h14, 32'h1, 2'b00);
		@(posedge clk_sys);
		chk("irq", 34'h0, {33'h0, irq});
		w0 = drive_state_word_ff;
		ce <= 1'b0;
		dir_reverse <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("frozen", {18'h0, w0}, {18'h0, drive_state_word_ff});
		ce <= 1'b1;
		repeat (5) @(posedge clk_sys);
		test_done();
	end
endmodule // drive_status_word_builder_bench
`default_nettype wire
